// [hdl/write_guard_pkg.sv]
// Constants, register map and bus carriers of the peripheral write guard
package write_guard_pkg;

	// ----------------------------------------------------------------
	// Bus widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;

	// ----------------------------------------------------------------
	// Register offsets (both names alias one protection vector)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] PROTECT_CLEAR_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] PROTECT_SET_OFS   = 8'h04;

	// ----------------------------------------------------------------
	// Slot positions, group A
	// ----------------------------------------------------------------
	localparam int EXT_IRQ_CTRL_SLOT = 6;
	localparam int CALENDAR_SLOT     = 5;
	localparam int WATCHDOG_SLOT     = 4;
	localparam int GEN_CLOCK_SLOT    = 3;
	localparam int SYSTEM_CTRL_SLOT  = 2;
	localparam int POWER_MGR_SLOT    = 1;

	// ----------------------------------------------------------------
	// Slot positions, group B
	// ----------------------------------------------------------------
	localparam int TRACE_BUFFER_SLOT = 6;
	localparam int IO_PORT_SLOT      = 3;
	localparam int NV_MEMORY_SLOT    = 2;
	localparam int SERVICE_UNIT_SLOT = 1;

	// ----------------------------------------------------------------
	// Implemented bits and reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] GROUP_A_VALID = 32'h0000_007E;
	localparam logic [DATA_W-1:0] GROUP_A_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] GROUP_B_VALID = 32'h0000_004E;
	localparam logic [DATA_W-1:0] GROUP_B_RESET = 32'h0000_0002;
	localparam logic [DATA_W-1:0] ZERO_WORD     = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Peripheral bus carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
		logic [STRB_W-1:0] pstrb;
	} bus_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} bus_rsp_s;

endpackage : write_guard_pkg

// [hdl/peripheral_write_guard.sv]
// Peripheral write guard: protection bits with clear/set aliases and write blocking
`timescale 1ns/100ps

// Summary of operation
// [R1] Byte, halfword and word accesses each complete as one indivisible bus transfer.
// [R2] Each byte lane of a protection register can be written alone, touching only that lane.
// [R3] A zero written to any position of the clear or set register leaves that bit unchanged.
// [R4] A one written to the clear register resets that protection bit to 0 (unprotected).
// [R5] Group A holds slots at bits 6 (irq ctrl), 5 (calendar), 4 (watchdog), 3 (clock), 2 (system), 1 (power).
// [R6] Group B holds slots at bits 6 (trace buffer), 3 (io port), 2 (nv memory), 1 (service unit).
// [R7] Group B resets to 0x000002, so only the service unit starts protected.
// [R8] Unused positions read as zero and ignore writes in both registers.
// [R9] A one written to the set register sets that protection bit, seen through both aliases.
// [R10] The clear and set registers read back the identical protection vector.
// [R11] A peripheral write to a protected slot is blocked and answered with an access error.
// [R12] Protecting a protected slot or unprotecting an unprotected slot gives an access error.
module peripheral_write_guard #(
	parameter bit GROUP_B = 1'b0
) (
	input  wire logic                             mclk,
	input  wire logic                             rst_n,
	input  wire write_guard_pkg::bus_req_s        bus_req,
	output      write_guard_pkg::bus_rsp_s        bus_rsp,
	input  wire logic [write_guard_pkg::DATA_W-1:0] periph_wr_req,
	output      logic [write_guard_pkg::DATA_W-1:0] periph_wr_err,
	output      logic [write_guard_pkg::DATA_W-1:0] protect_vec
);

	// ----------------------------------------------------------------
	// Group selection
	// ----------------------------------------------------------------
	localparam logic [write_guard_pkg::DATA_W-1:0] VALID_MASK =
		GROUP_B ? write_guard_pkg::GROUP_B_VALID : write_guard_pkg::GROUP_A_VALID; // R5 R6
	localparam logic [write_guard_pkg::DATA_W-1:0] RESET_VAL =
		GROUP_B ? write_guard_pkg::GROUP_B_RESET : write_guard_pkg::GROUP_A_RESET; // R7

	logic [write_guard_pkg::DATA_W-1:0] protect_reg;
	logic [write_guard_pkg::DATA_W-1:0] protect_next;
	logic [write_guard_pkg::DATA_W-1:0] rdata_reg;
	logic [write_guard_pkg::DATA_W-1:0] rdata_next;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire logic access_phase = bus_req.psel & bus_req.penable;
	wire logic setup_read   = bus_req.psel & ~bus_req.penable & ~bus_req.pwrite;
	wire logic hit_clear    = (bus_req.paddr == write_guard_pkg::PROTECT_CLEAR_OFS);
	wire logic hit_set      = (bus_req.paddr == write_guard_pkg::PROTECT_SET_OFS);
	wire logic mapped       = hit_clear | hit_set;
	wire logic do_write     = access_phase & bus_req.pwrite;

	// ----------------------------------------------------------------
	// Byte lane mask
	// ----------------------------------------------------------------
	logic [write_guard_pkg::DATA_W-1:0] lane_mask;

	// Reads ignore strobes; only writes are gated per lane
	localparam int LANE_W = write_guard_pkg::DATA_W / write_guard_pkg::STRB_W;
	genvar lane;
	generate
		for (lane = 0; lane < write_guard_pkg::STRB_W; lane++) begin : g_lane
			assign lane_mask[lane*LANE_W +: LANE_W] = {LANE_W{bus_req.pstrb[lane]}}; // R2
		end
	endgenerate

	// Unused bits masked off before any effect
	wire logic [write_guard_pkg::DATA_W-1:0] write_ones = bus_req.pwdata & lane_mask & VALID_MASK; // R8 R3
	wire logic [write_guard_pkg::DATA_W-1:0] clear_ones =
		(do_write & hit_clear) ? write_ones : write_guard_pkg::ZERO_WORD; // R4
	wire logic [write_guard_pkg::DATA_W-1:0] set_ones =
		(do_write & hit_set) ? write_ones : write_guard_pkg::ZERO_WORD; // R9

	// Double protect or double unprotect is a program-flow fault
	wire logic double_fault = (|(clear_ones & ~protect_reg)) | (|(set_ones & protect_reg)); // R12

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	assign protect_next = (protect_reg & ~clear_ones) | set_ones; // R3 R4 R9
	// Read data captured in setup so the access phase needs no wait state
	assign rdata_next   = setup_read ? (mapped ? protect_reg : write_guard_pkg::ZERO_WORD) : rdata_reg; // R10

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			protect_reg <= RESET_VAL; // R7
			rdata_reg   <= write_guard_pkg::ZERO_WORD;
		end else begin
			protect_reg <= protect_next; // R1
			rdata_reg   <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Zero wait: every access completes in its own access cycle
	wire logic ready_now = 1'b1; // R1
	// Unmapped offsets err as well, so a stray pointer is caught, not ignored
	wire logic err_now   = access_phase & (~mapped | (bus_req.pwrite & double_fault)); // R12
	assign bus_rsp       = '{prdata: rdata_reg, pready: ready_now, pslverr: err_now};
	assign protect_vec   = protect_reg;

	// ----------------------------------------------------------------
	// Peripheral guard
	// ----------------------------------------------------------------
	// Answers in the same cycle; a set write lands only at the edge that ends it
	assign periph_wr_err = periph_wr_req & protect_reg; // R11

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// Reset tracking for the assertions
	// ----------------------------------------------------------------
	logic first_cycle_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			first_cycle_reg <= 1'b1;
		end else begin
			first_cycle_reg <= 1'b0;
		end
	end

	chk_reset_value_load: assert property ( // R7
		first_cycle_reg |-> protect_reg == RESET_VAL)
		else $error("protection vector not at reset value");

	chk_clear_bits_drop: assert property ( // R4
		(do_write && hit_clear) |=> (protect_reg & $past(write_ones)) == write_guard_pkg::ZERO_WORD)
		else $error("clear write left a bit set");

	chk_set_bits_rise: assert property ( // R9
		(do_write && hit_set) |=> (protect_reg & $past(write_ones)) == $past(write_ones))
		else $error("set write left a bit clear");

	chk_zero_write_stable: assert property ( // R3
		(do_write && write_ones == write_guard_pkg::ZERO_WORD) |=> $stable(protect_reg))
		else $error("zero write changed protection");

	chk_lane_isolation: assert property ( // R2
		(do_write && !bus_req.pstrb[0]) |=> protect_reg[7:0] == $past(protect_reg[7:0]))
		else $error("unselected lane changed");

	chk_unused_bits_zero: assert property ( // R8
		(protect_reg & ~VALID_MASK) == write_guard_pkg::ZERO_WORD)
		else $error("unused bit set");

	chk_alias_read_same: assert property ( // R10
		(setup_read && mapped) ##1 access_phase |-> bus_rsp.prdata == $past(protect_reg))
		else $error("alias read differs from vector");

	chk_double_fault_err: assert property ( // R12
		(do_write && hit_set && |(write_ones & protect_reg)) |-> bus_rsp.pslverr)
		else $error("double protect not reported");

	chk_periph_block_err: assert property ( // R11
		periph_wr_err == (periph_wr_req & protect_reg))
		else $error("protected peripheral write not blocked");

	chk_idle_no_change: assert property ( // R1
		!do_write |=> $stable(protect_reg))
		else $error("vector changed without a write");

	chk_double_clear_err: assert property ( // R12
		(do_write && hit_clear && |(write_ones & ~protect_reg)) |-> bus_rsp.pslverr)
		else $error("double unprotect not reported");

	chk_clean_set_ok: assert property ( // R9
		(do_write && hit_set && (write_ones & protect_reg) == write_guard_pkg::ZERO_WORD) |-> !bus_rsp.pslverr)
		else $error("clean set answered with error");

	chk_clean_clear_ok: assert property ( // R4
		(do_write && hit_clear && (write_ones & ~protect_reg) == write_guard_pkg::ZERO_WORD) |-> !bus_rsp.pslverr)
		else $error("clean clear answered with error");

	chk_clear_keeps_others: assert property ( // R3
		(do_write && hit_clear) |=> (protect_reg & ~$past(write_ones)) == ($past(protect_reg) & ~$past(write_ones)))
		else $error("clear write touched an unwritten bit");

	chk_set_keeps_others: assert property ( // R3
		(do_write && hit_set) |=> (protect_reg & ~$past(write_ones)) == ($past(protect_reg) & ~$past(write_ones)))
		else $error("set write touched an unwritten bit");

	chk_unmapped_err: assert property ( // R8
		(access_phase && !mapped) |-> bus_rsp.pslverr)
		else $error("unmapped access not reported");

	chk_unmapped_no_write: assert property ( // R8
		(do_write && !mapped) |=> $stable(protect_reg))
		else $error("unmapped write changed protection");

	chk_unmapped_read_zero: assert property ( // R8
		(setup_read && !mapped) |=> bus_rsp.prdata == write_guard_pkg::ZERO_WORD)
		else $error("unmapped read not zero");

	chk_read_no_error: assert property ( // R10
		(access_phase && !bus_req.pwrite && mapped) |-> !bus_rsp.pslverr)
		else $error("mapped read answered with error");

	chk_err_access_only: assert property ( // R1
		!access_phase |-> !bus_rsp.pslverr)
		else $error("error outside access phase");

	chk_guard_valid_only: assert property ( // R11
		(periph_wr_err & ~VALID_MASK) == write_guard_pkg::ZERO_WORD)
		else $error("guard error on an unused slot");

	// Main scenarios
	cov_set_then_clear: cover property (
		(do_write && hit_set) ##[1:20] (do_write && hit_clear));
	cov_double_fault: cover property (
		bus_rsp.pslverr && mapped);
	cov_periph_blocked: cover property (
		|periph_wr_err);
	cov_alias_read: cover property (
		setup_read && hit_set ##1 access_phase);
	cov_double_clear: cover property (
		do_write && hit_clear && |(write_ones & ~protect_reg));

endmodule : peripheral_write_guard

// [verification/bus_master_model.sv]
// Register bus master model that drives the guard's register port
`timescale 1ns/100ps
module bus_master_model (
	input  wire logic                      mclk,
	input  wire write_guard_pkg::bus_rsp_s bus_rsp,
	output      write_guard_pkg::bus_req_s bus_req
);
	initial bus_req = '0;

	// ----------------------------------------------------------------
	// One transfer: setup, then access until ready
	// ----------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		int n;
		@(negedge mclk);
		bus_req = '{1'b1, 1'b0, w, a, d, (w ? s : 4'h0)};
		@(negedge mclk);
		bus_req.penable = 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (bus_rsp.pready !== 1'b1 && n < 8);
		rd = bus_rsp.prdata;
		err = bus_rsp.pslverr;
		// No ready within the limit poisons the answer so the caller's compare fails
		if (bus_rsp.pready !== 1'b1) err = 1'bx;
		@(negedge mclk);
		// Released lines show inverted junk, not the last value
		bus_req = '{1'b0, 1'b0, 1'b0, ~a, ~d, 4'h0};
	endtask : xfer
endmodule : bus_master_model

// [verification/peripheral_write_guard_test.sv]
// Self-checking bench of the write guard, both groups on one bus
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
	$display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module peripheral_write_guard_test;
	logic                      mclk;
	logic                      rst_n;
	logic [31:0]               req;
	logic [31:0]               rd;
	logic                      err;
	int                        fail_count;
	int                        n_compared;
	write_guard_pkg::bus_req_s bus_req;
	write_guard_pkg::bus_rsp_s rsp_a;
	write_guard_pkg::bus_rsp_s rsp_b;
	logic [31:0]               err_a;
	logic [31:0]               err_b;
	logic [31:0]               vec_a;
	logic [31:0]               vec_b;
	logic [31:0]               a_rd;
	logic                      a_err;
	localparam logic [7:0] CLR = write_guard_pkg::PROTECT_CLEAR_OFS;
	localparam logic [7:0] SET = write_guard_pkg::PROTECT_SET_OFS;

	// Master answers follow group B; group A is judged by its vector and its sampled answers
	bus_master_model u_bus_master_model (.mclk(mclk), .bus_rsp(rsp_b), .bus_req(bus_req));
	peripheral_write_guard #(.GROUP_B(1'b1)) u_peripheral_write_guard (.mclk(mclk), .rst_n(rst_n),
		.bus_req(bus_req), .bus_rsp(rsp_b), .periph_wr_req(req), .periph_wr_err(err_b), .protect_vec(vec_b));
	peripheral_write_guard #(.GROUP_B(1'b0)) u_peripheral_write_guard_a (.mclk(mclk), .rst_n(rst_n),
		.bus_req(bus_req), .bus_rsp(rsp_a), .periph_wr_req(req), .periph_wr_err(err_a), .protect_vec(vec_a));

	// Group A answers are taken at the same access edge as the master takes group B's
	always @(posedge mclk) begin
		if (bus_req.psel && bus_req.penable) begin
			a_rd  <= rsp_a.prdata;
			a_err <= rsp_a.pslverr;
		end
	end

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [31:0] erd, input logic eerr);
		u_bus_master_model.xfer(w, a, d, s, rd, err);
		if (!w) `CHK(rd, erd)
		`CHK(err, eerr)
	endtask : acc

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		req = '0;
		fail_count = 0;
		n_compared = 0;
		repeat (6) @(posedge mclk);
		@(negedge mclk) rst_n = 1'b1;
		`CHK(vec_b, 32'h0000_0002)
		`CHK(vec_a, 32'h0000_0000)
		acc(1'b0, CLR, '0, '0, 32'h0000_0002, 1'b0);
		acc(1'b0, SET, '0, '0, 32'h0000_0002, 1'b0);
		$display("test reset values done");
		// Service unit already protected, so the set errs but the rest lands
		acc(1'b1, SET, 32'hFFFF_FFFF, 4'hF, '0, 1'b1);
		`CHK(a_err, 1'b0)
		`CHK(vec_b, 32'h0000_004E)
		`CHK(vec_a, 32'h0000_007E)
		acc(1'b0, CLR, '0, '0, 32'h0000_004E, 1'b0);
		@(negedge mclk) req = 32'hFFFF_FFFF;
		#1 `CHK(err_b, 32'h0000_004E)
		`CHK(err_a, 32'h0000_007E)
		@(negedge mclk) req = '0;
		$display("test set and guard done");
		acc(1'b1, CLR, 32'hFFFF_FF04, 4'h1, '0, 1'b0);
		`CHK(vec_b, 32'h0000_004A)
		`CHK(vec_a, 32'h0000_007A)
		acc(1'b1, CLR, 32'h0000_0004, 4'h3, '0, 1'b1);
		`CHK(a_err, 1'b1)
		`CHK(vec_b, 32'h0000_004A)
		acc(1'b1, CLR, 32'h0000_0048, 4'hF, '0, 1'b0);
		acc(1'b0, SET, '0, '0, 32'h0000_0002, 1'b0);
		`CHK(vec_a, 32'h0000_0032)
		`CHK(a_rd, 32'h0000_0032)
		acc(1'b0, 8'h08, '0, '0, 32'h0000_0000, 1'b1);
		$display("test clear and unmapped done");
		acc(1'b1, SET, 32'h0000_0000, 4'hF, '0, 1'b0);
		acc(1'b1, SET, 32'h0000_0040, 4'hE, '0, 1'b0);
		`CHK(vec_b, 32'h0000_0002)
		acc(1'b1, SET, 32'h0000_0040, 4'hF, '0, 1'b0);
		`CHK(vec_a, 32'h0000_0072)
		acc(1'b0, CLR, '0, '0, 32'h0000_0042, 1'b0);
		`CHK(a_rd, 32'h0000_0072)
		$display("test lanes and zero writes done");
		@(negedge mclk) rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk) rst_n = 1'b1;
		`CHK(vec_b, 32'h0000_0002)
		`CHK(vec_a, 32'h0000_0000)
		acc(1'b0, SET, '0, '0, 32'h0000_0002, 1'b0);
		$display("test mid-run reset done");
		end_of_test();
	end

	initial begin
		#20000;
		fail_count++;
		end_of_test();
	end
endmodule : peripheral_write_guard_test
